// ---- rtl/uvrb_pkg.sv ----
// Function
// - decode vendor space 30h to 3Fh only
// - serve immediate reads and writes in range
// - boost bits 6:5 select HS amplitude
// - headset audio on only at 1010
// - conversion register read 36-38, write/set/clear
// - result bits 2:0 encode ID resistance
// - done bit 3 set after 282us conversion
// - vendor result read clears done
// - carkit status read leaves done alone
// - result and done mirrored to carkit
// - start bit rising begins measurement
// - start bit self-clears at completion
// - enabled done raises alt_int
// - interrupt enable is OR of both
// - event latch on enabled done rise, read clears
`default_nettype none

package uvrb_pkg;
  localparam logic [5:0] UVRB_VEND_LO    = 6'h30;
  localparam logic [5:0] UVRB_VEND_HI    = 6'h3f;
  localparam logic [5:0] UVRB_ADDR_BOOST = 6'h31;
  localparam logic [5:0] UVRB_ADDR_AUDIO = 6'h33;
  localparam logic [5:0] UVRB_ADDR_CONV  = 6'h36;
  localparam logic [5:0] UVRB_ADDR_CSET  = 6'h37;
  localparam logic [5:0] UVRB_ADDR_CCLR  = 6'h38;

  // writable bit masks
  localparam logic [7:0] UVRB_BOOST_MASK = 8'h60;
  localparam logic [7:0] UVRB_AUDIO_MASK = 8'h0f;
  localparam logic [7:0] UVRB_CONV_MASK  = 8'h77;

  localparam int         UVRB_BOOST_LSB  = 5;
  localparam int         UVRB_CODE_LSB   = 0;
  localparam int         UVRB_DONE_BIT   = 3;
  localparam int         UVRB_START_BIT  = 4;
  localparam int         UVRB_IRQEN_BIT  = 6;
  localparam logic [3:0] UVRB_AUDIO_KEY  = 4'ha;
  localparam logic [7:0] UVRB_RESET_VAL  = 8'h00;

  // result codes
  localparam logic [2:0] UVRB_RID_0R     = 3'h0;
  localparam logic [2:0] UVRB_RID_75R    = 3'h1;
  localparam logic [2:0] UVRB_RID_100K   = 3'h2;
  localparam logic [2:0] UVRB_RID_200K   = 3'h3;
  localparam logic [2:0] UVRB_RID_440K   = 3'h4;
  localparam logic [2:0] UVRB_RID_FLOAT  = 3'h5;
  localparam logic [2:0] UVRB_RID_ERROR  = 3'h7;

  localparam int UVRB_CLK_PERIOD_NS = 20;
  localparam int UVRB_CONV_TIME_NS  = 282000;
  localparam int UVRB_CONV_CYCLES   = UVRB_CONV_TIME_NS / UVRB_CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    UVRB_OP_WRITE = 2'b00,
    UVRB_OP_SET   = 2'b01,
    UVRB_OP_CLEAR = 2'b10
  } uvrb_op_e;
endpackage : uvrb_pkg

`default_nettype wire

// ---- rtl/uvrb_conv_timer.sv ----
`default_nettype none

module uvrb_conv_timer #(
  parameter int CYCLES = 14100
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic ce,
  input  wire logic start,
  input  wire logic abort,
  output logic      busy,
  output logic      finish
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count  <= '0;
      busy   <= 1'b0;
      finish <= 1'b0;
    end else if (ce) begin
      finish <= 1'b0;
      if (start) begin
        count <= '0;
        busy  <= 1'b1;
      end else if (abort) begin
        busy <= 1'b0;
      end else if (busy) begin
        if (count == LAST) begin
          busy   <= 1'b0;
          finish <= 1'b1;
        end else begin
          count <= count + CW'(1);
        end
      end
    end
  end
endmodule // uvrb_conv_timer

`default_nettype wire

// ---- rtl/uvrb_top.sv ----
`default_nettype none

module uvrb_top
  import uvrb_pkg::*;
#(
  parameter int CONV_CYCLES = uvrb_pkg::UVRB_CONV_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  input  wire logic [2:0] id_adc_code,
  input  wire logic       carkit_irq_enable,
  input  wire logic       carkit_status_rd,
  input  wire logic       carkit_latch_rd,
  output logic      [1:0] hs_boost,
  output logic            headset_audio_en,
  output logic            id_conv_measure,
  output logic      [2:0] id_resistance_code,
  output logic            id_conv_done,
  output logic            id_conv_event_latch,
  output logic            alt_int
);
  import uvrb_pkg::*;

  logic [7:0] boost_reg;
  logic [7:0] audio_reg;
  logic [7:0] conv_reg;
  logic       done_q;
  logic [7:0] next_conv;
  logic [7:0] conv_view;
  logic       in_vendor;
  logic       conv_addr;
  logic       conv_wr;
  logic       start_rise;
  logic       start_fall;
  logic       conv_busy;
  logic       conv_finish;
  logic       irq_en;
  logic       done_rise;

  function automatic logic [7:0] apply_op(input uvrb_op_e op, input logic [7:0] old,
                                          input logic [7:0] wd, input logic [7:0] mask);
    logic [7:0] val;
    val = old;
    case (op)
      UVRB_OP_WRITE: val = wd;
      UVRB_OP_SET:   val = old | wd;
      UVRB_OP_CLEAR: val = old & ~wd;
      default:       val = old;
    endcase
    apply_op = (old & ~mask) | (val & mask);
  endfunction

  function automatic logic [2:0] rid_code(input logic [2:0] raw);
    case (raw)
      UVRB_RID_0R:    rid_code = UVRB_RID_0R;
      UVRB_RID_75R:   rid_code = UVRB_RID_75R;
      UVRB_RID_100K:  rid_code = UVRB_RID_100K;
      UVRB_RID_200K:  rid_code = UVRB_RID_200K;
      UVRB_RID_440K:  rid_code = UVRB_RID_440K;
      UVRB_RID_FLOAT: rid_code = UVRB_RID_FLOAT;
      // unlisted code has no meaning, so report it as error
      default:        rid_code = UVRB_RID_ERROR;
    endcase
  endfunction

  assign in_vendor = (reg_addr >= UVRB_VEND_LO) && (reg_addr <= UVRB_VEND_HI);
  assign conv_addr = (reg_addr == UVRB_ADDR_CONV) || (reg_addr == UVRB_ADDR_CSET) ||
                     (reg_addr == UVRB_ADDR_CCLR);
  assign conv_wr   = reg_wr && conv_addr;

  always_comb begin
    next_conv = conv_reg;
    if (conv_wr) begin
      case (reg_addr)
        UVRB_ADDR_CSET: next_conv = apply_op(UVRB_OP_SET, conv_reg, reg_wdata, UVRB_CONV_MASK);
        UVRB_ADDR_CCLR: next_conv = apply_op(UVRB_OP_CLEAR, conv_reg, reg_wdata, UVRB_CONV_MASK);
        default:        next_conv = apply_op(UVRB_OP_WRITE, conv_reg, reg_wdata, UVRB_CONV_MASK);
      endcase
    end
  end

  assign start_rise = conv_wr && next_conv[UVRB_START_BIT] && !conv_reg[UVRB_START_BIT];
  // clearing start by software abandons the measurement
  assign start_fall = conv_wr && !next_conv[UVRB_START_BIT] && conv_reg[UVRB_START_BIT];

  uvrb_conv_timer #(
    .CYCLES (CONV_CYCLES)
  ) u_timer (
    .clock   (clock),
    .sys_rst (sys_rst),
    .ce      (ce),
    .start   (start_rise),
    .abort   (start_fall),
    .busy    (conv_busy),
    .finish  (conv_finish)
  );

  // conversion register; hardware completion outranks software, except a start rise in the same cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      conv_reg <= UVRB_RESET_VAL;
    end else if (ce) begin
      conv_reg <= next_conv;
      if (conv_finish && !start_rise) begin
        conv_reg[UVRB_CODE_LSB +: 3] <= rid_code(id_adc_code);
        conv_reg[UVRB_START_BIT]     <= 1'b0;
      end
    end
  end

  // done flag: set wins over read-clear
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      done_q <= 1'b0;
    end else if (ce) begin
      if (conv_finish && !start_rise) begin
        done_q <= 1'b1;
      end else if (reg_rd && conv_addr) begin
        done_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      boost_reg <= UVRB_RESET_VAL;
      audio_reg <= UVRB_RESET_VAL;
    end else if (ce && reg_wr) begin
      if (reg_addr == UVRB_ADDR_BOOST) begin
        boost_reg <= apply_op(UVRB_OP_WRITE, boost_reg, reg_wdata, UVRB_BOOST_MASK);
      end
      if (reg_addr == UVRB_ADDR_AUDIO) begin
        audio_reg <= apply_op(UVRB_OP_WRITE, audio_reg, reg_wdata, UVRB_AUDIO_MASK);
      end
    end
  end

  assign conv_view = {1'b0, conv_reg[6:4], done_q, conv_reg[2:0]};

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd && in_vendor;
      if (reg_rd && in_vendor) begin
        if (reg_addr == UVRB_ADDR_BOOST) begin
          reg_rdata <= boost_reg & UVRB_BOOST_MASK;
        end else if (reg_addr == UVRB_ADDR_AUDIO) begin
          reg_rdata <= audio_reg & UVRB_AUDIO_MASK;
        end else if (conv_addr) begin
          reg_rdata <= conv_view;
        end else begin
          reg_rdata <= 8'h00;
        end
      end
    end
  end

  assign irq_en    = conv_reg[UVRB_IRQEN_BIT] || carkit_irq_enable;
  // id_conv_done doubles as last cycle's done
  assign done_rise = done_q && !id_conv_done;

  // pin outputs; carkit status reads have no side effect here
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hs_boost           <= 2'b00;
      headset_audio_en   <= 1'b0;
      id_conv_measure    <= 1'b0;
      id_resistance_code <= 3'h0;
      id_conv_done       <= 1'b0;
      alt_int            <= 1'b0;
    end else if (ce) begin
      hs_boost           <= boost_reg[UVRB_BOOST_LSB +: 2];
      headset_audio_en   <= (audio_reg[3:0] == UVRB_AUDIO_KEY);
      id_conv_measure    <= conv_busy;
      id_resistance_code <= conv_reg[UVRB_CODE_LSB +: 3];
      id_conv_done       <= done_q;
      alt_int            <= done_rise && irq_en;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      id_conv_event_latch <= 1'b0;
    end else if (ce) begin
      if (done_rise && irq_en) begin
        id_conv_event_latch <= 1'b1;
      end else if (carkit_latch_rd) begin
        id_conv_event_latch <= 1'b0;
      end
    end
  end
endmodule // uvrb_top

`default_nettype wire

// ---- tb/uvrb_top_asserts.sv ----
`default_nettype none
module uvrb_top_asserts #(
  parameter int CONV_CYCLES = 14100
) (
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic       ce,
  input wire logic [5:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       carkit_irq_enable,
  input wire logic       carkit_status_rd,
  input wire logic       carkit_latch_rd,
  input wire logic       headset_audio_en,
  input wire logic       id_conv_measure,
  input wire logic       id_conv_done,
  input wire logic       id_conv_event_latch,
  input wire logic       alt_int
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  int meas_cnt;
  // edges the measurement really ran, frozen edges left out
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meas_cnt <= 0;
    end else if (!id_conv_measure) begin
      meas_cnt <= 0;
    end else if (ce) begin
      meas_cnt <= meas_cnt + 1;
    end
  end
  property p_rvalid; ce && reg_rd |=> reg_rvalid == ($past(reg_addr) >= 6'h30); endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer wrong");
  property p_audio; reg_rvalid && $past(reg_addr) == 6'h33
    |-> reg_rdata[7:4] == 4'h0 && headset_audio_en == (reg_rdata[3:0] == 4'ha); endproperty
  a_audio: assert property (p_audio) else $error("audio key wrong");
  property p_conv; reg_rvalid && $past(reg_addr) inside {[6'h36:6'h38]} |-> !reg_rdata[7] ##1 !id_conv_done; endproperty
  a_conv: assert property (p_conv) else $error("done not cleared");
  property p_stat; carkit_status_rd && id_conv_done && !reg_rd && !$past(reg_rd) |=> id_conv_done; endproperty
  a_stat: assert property (p_stat) else $error("status read lost done");
  property p_src; alt_int |-> $rose(id_conv_done); endproperty
  a_src: assert property (p_src) else $error("stray alt_int");
  property p_or; $rose(id_conv_done) && $past(carkit_irq_enable) |-> alt_int; endproperty
  a_or: assert property (p_or) else $error("alt_int missing");
  property p_latch; alt_int |-> id_conv_event_latch; endproperty
  a_latch: assert property (p_latch) else $error("latch not set");
  property p_lclr; carkit_latch_rd |=> !id_conv_event_latch || alt_int; endproperty
  a_lclr: assert property (p_lclr) else $error("latch not cleared");
  property p_meas; $rose(id_conv_measure) |-> id_conv_measure[*8]; endproperty
  a_meas: assert property (p_meas) else $error("measure too short");
  property p_len; $rose(id_conv_done) |-> $past(meas_cnt) == CONV_CYCLES; endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");
endmodule // uvrb_top_asserts
bind uvrb_top uvrb_top_asserts #(.CONV_CYCLES(CONV_CYCLES)) uvrb_top_asserts_inst (.clock, .sys_rst, .ce, .reg_addr,
  .reg_rd, .reg_rdata, .reg_rvalid, .carkit_irq_enable, .carkit_status_rd, .carkit_latch_rd, .headset_audio_en,
  .id_conv_measure, .id_conv_done, .id_conv_event_latch, .alt_int);
`default_nettype wire

// ---- tb/uvrb_link_model.sv ----
`default_nettype none
module uvrb_link_model (
  input  wire logic       clock,
  output logic      [5:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 6'h0;
    reg_wdata = 8'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] m;
    m = (a inside {[6'h36:6'h38]}) ? (d & 8'hdf) : d;
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= m;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    // idle lines inverted so stale values never pass
    reg_addr <= ~a;
    reg_wdata <= ~m;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic v);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule // uvrb_link_model
`default_nettype wire

// ---- tb/tb_uvrb_top.sv ----
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; $display("mismatch at %0t: got %h want %h", $time, a, e); end end
module tb_uvrb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CONV = 20;
  logic       clock = 0, sys_rst = 1, ce = 1, carkit_irq_enable = 0, carkit_status_rd = 0, carkit_latch_rd = 0;
  logic       reg_wr, reg_rd, reg_rvalid, v, headset_audio_en, id_conv_measure, id_conv_done, id_conv_event_latch;
  logic       alt_int;
  logic [1:0] hs_boost;
  logic [2:0] id_adc_code = 0, id_resistance_code;
  logic [5:0] reg_addr, a;
  logic [7:0] reg_wdata, reg_rdata, d, w;
  int         n_mismatch = 0, check_count = 0, i, k;
  uvrb_top #(.CONV_CYCLES(CONV)) uvrb_top_inst (.clock, .sys_rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .reg_rvalid, .id_adc_code, .carkit_irq_enable, .carkit_status_rd, .carkit_latch_rd, .hs_boost,
    .headset_audio_en, .id_conv_measure, .id_resistance_code, .id_conv_done, .id_conv_event_latch, .alt_int);
  uvrb_link_model uvrb_link_model_inst (.clock, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid);
  initial forever #10 clock = ~clock;
  function automatic logic [7:0] vexp(input logic [5:0] ra, input logic [7:0] wd);
    return ra == 6'h31 ? wd & 8'h60 : wd & 8'h0f;
  endfunction
  function automatic logic [7:0] cexp(input logic [2:0] c, input logic ie, input logic dn);
    return {1'b0, ie, 2'b00, dn, c};
  endfunction
  task automatic rb(input logic [5:0] ra, input logic [7:0] e);
    uvrb_link_model_inst.rd(ra, d, v);
    `CHK({v, d}, {1'b1, e})
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100us;
    n_mismatch++;
    results();
  end
  initial begin
    void'($urandom(32'h8e26d8c6));
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    rb(6'h31, 8'h00);
    rb(6'h33, 8'h00);
    rb(6'h36, 8'h00);
    rb(6'h3f, 8'h00);
    uvrb_link_model_inst.rd(6'h20, d, v);
    `CHK(v, 1'b0)
    for (i = 0; i < 24; i++) begin
      a = i[0] ? 6'h33 : 6'h31;
      w = i == 1 ? 8'hfa : i == 3 ? 8'h0b : 8'($urandom);
      uvrb_link_model_inst.wr(a, w);
      rb(a, vexp(a, w));
      if (i[0]) `CHK(headset_audio_en, w[3:0] == 4'ha)
      else `CHK(hs_boost, w[6:5])
    end
    for (k = 0; k < 8; k++) begin
      if (k == 6) continue;
      id_adc_code <= k[2:0];
      carkit_irq_enable <= k[1];
      uvrb_link_model_inst.wr(k[0] ? 6'h37 : 6'h36, {1'b0, k[2], 6'h10});
      i = 0;
      while (id_conv_done !== 1'b1 && i < 60) begin
        @(posedge clock);
        i++;
        // one pass freezes five edges mid-conversion
        if (k == 3) ce <= (i < 4 || i > 8);
      end
      `CHK(i, CONV + 3 + (k == 3 ? 5 : 0))
      `CHK({alt_int, id_conv_measure}, {k[1] | k[2], 1'b0})
      `CHK(id_resistance_code, k[2:0])
      `CHK(id_conv_event_latch, k[1] | k[2])
      @(posedge clock);
      `CHK(alt_int, 1'b0)
      carkit_status_rd <= 1'b1;
      carkit_latch_rd <= 1'b1;
      @(posedge clock);
      carkit_status_rd <= 1'b0;
      carkit_latch_rd <= 1'b0;
      #1;
      `CHK({id_conv_done, id_conv_event_latch}, 2'b10)
      rb(6'h36 + 6'(k % 3), cexp(k[2:0], k[2], 1'b1));
      rb(6'h36, cexp(k[2:0], k[2], 1'b0));
      uvrb_link_model_inst.wr(6'h38, 8'h40);
      rb(6'h37, cexp(k[2:0], 1'b0, 1'b0));
    end
    results();
  end
endmodule // tb_uvrb_top
`default_nettype wire
